/* dv/pmpl_partner.sv */
// far-side model: battery monitor, regulators, bus agent, wake source and dram
`default_nettype none
module pmpl_partner (
    input  wire logic clk_i,
    input  wire logic bat_low_i,
    input  wire logic busy_i,
    input  wire logic on_ac_i,
    input  wire logic rails_good_i,
    input  wire logic wake_i,
    input  wire logic dram_reset_n_i,
    input  wire logic dram_reset_oe_i,
    output logic      battery_low_n_o,
    output logic      bus_activity_n_o,
    output logic      ac_power_present_o,
    output logic      core_power_good_o,
    output logic      wake_request_o,
    output logic      dram_in_reset_o
);
    timeunit 1ns;
    timeprecision 1ps;
    wire dram_line;
    // open drain: a released line floats up to its pull-up and reads high
    assign dram_line       = dram_reset_oe_i ? dram_reset_n_i : 1'b1;
    assign dram_in_reset_o = (dram_line === 1'b0);
    // pins are unknown until the first edge, which the bench reset covers
    // pins move one clock after the request, like a slow external source
    always @(posedge clk_i) begin
        battery_low_n_o    <= !bat_low_i;
        bus_activity_n_o   <= !busy_i;
        ac_power_present_o <= on_ac_i;
        core_power_good_o  <= rails_good_i;
        wake_request_o     <= wake_i;
    end
endmodule // pmpl_partner
`default_nettype wire

/* dv/testbench.sv */
// self-checking testbench of the power management pin logic
`default_nettype none
`define CHK(got, exp) check_val(32'(got), 32'(exp))
module testbench
    import pmpl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned HARD  = 20;
    localparam int          LIMIT = 20000;
    logic        clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack;
    logic [7:0]  wb_adr;
    logic [3:0]  wb_sel, nat, gp;
    logic [31:0] wb_wdat, wb_rdat, rd;
    logic        bat_low, busy, on_ac, rails_good, wake, ac, only;
    logic        bat_n, busy_n, ac_p, pg, wake_rq, dram_held;
    logic        vid0, vid1, gate_n, plt_n, dram_n, dram_oe, sync, smi_n, irq, wake_o, deep;
    logic [1:0]  s;
    int          n_mismatch, cmp_count, cycles, wake_cnt, plt_low, i;

    pmpl_top #(.HARD_CYCLES(HARD)) u_pmpl_top (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
        .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .battery_low_n_i(bat_n),
        .bus_activity_n_i(busy_n), .ac_power_present_i(ac_p), .core_power_good_i(pg),
        .wake_request_i(wake_rq), .core_voltage_id_bit0_o(vid0),
        .core_voltage_id_bit1_o(vid1), .external_gate_n_o(gate_n),
        .platform_reset_n_o(plt_n), .dram_reset_n_o(dram_n), .dram_reset_oe_o(dram_oe),
        .pm_sync_line_o(sync), .system_mgmt_interrupt_n_o(smi_n), .irq_o(irq),
        .wake_o(wake_o), .deep_sleep_state_o(deep));

    pmpl_partner u_pmpl_partner (
        .clk_i(clk_i), .bat_low_i(bat_low), .busy_i(busy), .on_ac_i(on_ac),
        .rails_good_i(rails_good), .wake_i(wake), .dram_reset_n_i(dram_n),
        .dram_reset_oe_i(dram_oe), .battery_low_n_o(bat_n), .bus_activity_n_o(busy_n),
        .ac_power_present_o(ac_p), .core_power_good_o(pg), .wake_request_o(wake_rq),
        .dram_in_reset_o(dram_held));

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // pulse and low-time monitors, plus the hang guard
    always @(posedge clk_i) begin
        cycles++;
        if (wake_o === 1'b1) wake_cnt++;
        if (rst_i === 1'b0 && plt_n === 1'b0) plt_low++;
        if (cycles >= LIMIT) begin
            n_mismatch++;
            $display("timeout at %0t", $time);
            end_sim();
        end
    end

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one classic cycle; entered just after a rising edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        wb_cyc  <= 1'b1;
        wb_stb  <= 1'b1;
        wb_we   <= w;
        wb_adr  <= a;
        wb_wdat <= d;
        wb_sel  <= 4'hF;
        // no local limit: only the hang guard ends a wait for ack
        do begin
            @(posedge clk_i);
        end while (wb_ack !== 1'b1);
        rd = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clk_i);
        `CHK(wb_ack, 1'b0);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // counters are cleared away from the edge so the monitor never races
    task automatic arm();
        @(negedge clk_i);
        wake_cnt = 0;
        plt_low  = 0;
        @(posedge clk_i);
    endtask

    function automatic logic exp_pin(input logic native, input logic gpio);
        return native ? 1'b1 : gpio;
    endfunction

    function automatic logic exp_deep(input logic [1:0] sl, input logic a, input logic o);
        return (sl >= 2'd2) && !(o && a);
    endfunction

    initial begin
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_wdat} = '0;
        {bat_low, busy, wake, on_ac, rails_good} = 5'b00011;
        {n_mismatch, cmp_count, cycles, wake_cnt, plt_low} = '0;
        rst_i = 1'b1;
        void'($urandom(8));
        tick(16);
        rst_i <= 1'b0;
        tick(1);
        `CHK({vid0, vid1}, 2'b11);
        `CHK(gate_n, 1'b1);
        `CHK(plt_n, 1'b0);
        `CHK(dram_held, 1'b1);
        wb(1'b0, OFS_NATIVE, '0);
        `CHK(rd, NATIVE_RST);
        wb(1'b1, 8'h3C, 32'hFFFF_FFFF);
        wb(1'b0, 8'h3C, '0);
        `CHK(rd, 32'h0);
        $display("test reset values done");

        // pin mux, with all-gpio and all-native corners first
        for (i = 0; i < 8; i++) begin
            nat = (i == 0) ? 4'h0 : (i == 1) ? 4'hF : 4'($urandom);
            gp  = (i == 1) ? 4'h0 : 4'($urandom);
            wb(1'b1, OFS_GPIO_OUT, 32'(gp));
            wb(1'b1, OFS_NATIVE, 32'(nat));
            tick(2);
            `CHK(vid0, exp_pin(nat[PIN_VID0], gp[PIN_VID0]));
            `CHK(vid1, exp_pin(nat[PIN_VID1], gp[PIN_VID1]));
            `CHK(gate_n, exp_pin(nat[PIN_GATE], gp[PIN_GATE]));
            `CHK(plt_n, exp_pin(nat[PIN_PLT], gp[PIN_PLT]));
        end
        wb(1'b1, OFS_NATIVE, 32'(NATIVE_RST));
        $display("test pin mux done");

        rails_good <= 1'b0;
        tick(8);
        `CHK(plt_n, 1'b0);
        wb(1'b0, OFS_INT_STATUS, '0);
        `CHK(rd[EV_PG_LOST], 1'b1);
        rails_good <= 1'b1;
        tick(8);
        `CHK(plt_n, 1'b1);
        wb(1'b1, OFS_INT_CLEAR, 32'h1F);
        arm();
        wb(1'b1, OFS_RESET_CTRL, 32'(1 << RST_CTRL_HARD));
        wb(1'b0, OFS_RESET_CTRL, '0);
        `CHK(rd[RST_CTRL_HARD], 1'b1);
        tick(HARD + 8);
        `CHK(plt_low, HARD);
        $display("test platform reset done");

        wb(1'b1, OFS_CTRL, 32'(1 << CTRL_SMI_EN));
        wb(1'b1, OFS_INT_ENABLE, 32'(1 << EV_LOWBAT));
        bat_low <= 1'b1;
        tick(8);
        `CHK({smi_n, irq}, 2'b01);
        wb(1'b1, OFS_INT_CLEAR, 32'(1 << EV_LOWBAT));
        tick(2);
        `CHK({smi_n, irq}, 2'b10);
        // wake refused in every sleep state while battery is low, then accepted
        for (i = 0; i < 6; i++) begin
            if (i == 3) bat_low <= 1'b0;
            s = (i < 3) ? 2'(i + 1) : 2'(1 + $urandom % 3);
            wb(1'b1, OFS_SLEEP, 32'(s));
            tick(6);
            arm();
            wake <= 1'b1;
            tick(8);
            wake <= 1'b0;
            tick(4);
            `CHK(wake_cnt, (i < 3) ? 0 : 1);
            wb(1'b0, OFS_SLEEP, '0);
            `CHK(rd[1:0], (i < 3) ? s : 2'd0);
        end
        $display("test battery low done");

        for (i = 0; i < 4; i++) begin
            wb(1'b1, OFS_CTRL, 32'(i << CTRL_BM_FLAG_EN));
            wb(1'b1, OFS_PM_STATUS, 32'h1);
            busy <= 1'b1;
            tick(8);
            `CHK(sync, i[1]);
            wb(1'b0, OFS_PM_STATUS, '0);
            `CHK(rd[PMS_BM_FLAG], i[0]);
            busy <= 1'b0;
            tick(8);
        end
        $display("test bus activity done");

        for (i = 0; i < 10; i++) begin
            s    = (i == 0) ? 2'd2 : 2'($urandom);
            ac   = (i == 0) ? 1'b0 : 1'($urandom);
            only = (i == 0) ? 1'b1 : 1'($urandom);
            wb(1'b1, OFS_CTRL, 32'((1 << CTRL_DEEP_EN) | (only << CTRL_BATT_ONLY)));
            wb(1'b1, OFS_SLEEP, 32'(s));
            on_ac <= ac;
            tick(8);
            `CHK(deep, exp_deep(s, ac, only));
        end
        $display("test deep sleep done");

        `CHK(dram_held, 1'b1);
        wb(1'b1, OFS_CTRL, 32'(1 << CTRL_DRAM_REL));
        tick(2);
        `CHK(dram_held, 1'b0);
        $display("test dram reset done");
        end_sim();
    end
endmodule // testbench
`undef CHK
`default_nettype wire

/* src/pmpl_pkg.sv */
// package: constants, register map and state types of the power management pin logic
`default_nettype none
package pmpl_pkg;
    // clock and hard reset stretch
    localparam int unsigned CLK_FREQ_HZ          = 40_000_000;
    localparam int unsigned HARD_RESET_TIME_US   = 1000;
    localparam int unsigned HARD_RESET_CYCLES    =
        (CLK_FREQ_HZ / 1_000_000) * HARD_RESET_TIME_US;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL       = 8'h00;
    localparam logic [7:0] OFS_NATIVE     = 8'h04;
    localparam logic [7:0] OFS_GPIO_OUT   = 8'h08;
    localparam logic [7:0] OFS_SLEEP      = 8'h0C;
    localparam logic [7:0] OFS_RESET_CTRL = 8'h10;
    localparam logic [7:0] OFS_PM_STATUS  = 8'h14;
    localparam logic [7:0] OFS_INT_STATUS = 8'h18;
    localparam logic [7:0] OFS_INT_CLEAR  = 8'h1C;
    localparam logic [7:0] OFS_INT_ENABLE = 8'h20;
    localparam logic [7:0] OFS_PIN_STATUS = 8'h24;

    // control register fields
    localparam int CTRL_SMI_EN     = 0;
    localparam int CTRL_BM_FLAG_EN = 1;
    localparam int CTRL_BM_SYNC_EN = 2;
    localparam int CTRL_DEEP_EN    = 3;
    localparam int CTRL_BATT_ONLY  = 4;
    localparam int CTRL_DRAM_REL   = 5;
    localparam int CTRL_W          = 6;

    // pin select fields, shared by native and gpio output registers
    localparam int PIN_VID0 = 0;
    localparam int PIN_VID1 = 1;
    localparam int PIN_GATE = 2;
    localparam int PIN_PLT  = 3;
    localparam int MUX_W    = 4;

    // synchronised input vector
    localparam int IN_LOWBAT = 0;
    localparam int IN_BUSY   = 1;
    localparam int IN_AC     = 2;
    localparam int IN_PG     = 3;
    localparam int IN_WAKE   = 4;
    localparam int IN_W      = 5;

    // event bits of interrupt status, clear and enable
    localparam int EV_LOWBAT  = 0;
    localparam int EV_BUSY    = 1;
    localparam int EV_BLOCKED = 2;
    localparam int EV_WAKE    = 3;
    localparam int EV_PG_LOST = 4;
    localparam int EV_W       = 5;

    localparam int RST_CTRL_HARD = 1;
    localparam int PMS_BM_FLAG   = 0;

    // reset values
    localparam logic [CTRL_W-1:0] CTRL_RST   = 6'h00;
    localparam logic [MUX_W-1:0]  NATIVE_RST = 4'hF;
    localparam logic [MUX_W-1:0]  GPIO_RST   = 4'h0;
    localparam logic [EV_W-1:0]   EV_RST     = 5'h00;

    typedef enum logic [1:0] {PMPL_S0, PMPL_S3, PMPL_S4, PMPL_S5} pmpl_sleep_t;

    typedef struct packed {
        logic [CTRL_W-1:0] ctrl;
        logic [MUX_W-1:0]  native;
        logic [MUX_W-1:0]  gpio_out;
        pmpl_sleep_t       sleep;
        logic              bm_flag;
        logic [EV_W-1:0]   int_sts;
        logic [EV_W-1:0]   int_en;
        logic              bat_low_q;
        logic              busy_q;
        logic              wake_q;
        logic              pg_q;
        logic              ack;
        logic [31:0]       rdata;
        logic              vid0;
        logic              vid1;
        logic              gate_n;
        logic              plt_n;
        logic              dram_n;
        logic              dram_oe;
        logic              sync;
        logic              smi_n;
        logic              irq;
        logic              wake;
        logic              deep;
    } pmpl_state_t;

    localparam pmpl_state_t STATE_RST = '{
        ctrl: CTRL_RST, native: NATIVE_RST, gpio_out: GPIO_RST, sleep: PMPL_S0,
        bm_flag: 1'b0, int_sts: EV_RST, int_en: EV_RST,
        bat_low_q: 1'b0, busy_q: 1'b0, wake_q: 1'b0, pg_q: 1'b0,
        ack: 1'b0, rdata: 32'h0000_0000,
        vid0: 1'b1, vid1: 1'b1, gate_n: 1'b1, plt_n: 1'b0,
        dram_n: 1'b0, dram_oe: 1'b1, sync: 1'b0, smi_n: 1'b1,
        irq: 1'b0, wake: 1'b0, deep: 1'b0};
endpackage
`default_nettype wire

/* src/pmpl_pulse.sv */
// retriggerable pulse stretcher, busy for exactly CYCLES clocks after start
`default_nettype none
module pmpl_pulse #(
    parameter int unsigned CYCLES = 40000
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic start_i,
    output logic      busy_o
);
    localparam int CW = $clog2(CYCLES + 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          busy;
    } pmpl_pulse_t;

    pmpl_pulse_t s;
    pmpl_pulse_t next_s;

    always_comb begin
        next_s = s;
        if (start_i) begin
            next_s.cnt = CW'(CYCLES);
        end else if (s.cnt != '0) begin
            next_s.cnt = s.cnt - CW'(1);
        end
        next_s.busy = (next_s.cnt != '0);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '{cnt: '0, busy: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    assign busy_o = s.busy;
endmodule // pmpl_pulse
`default_nettype wire

/* src/pmpl_sync.sv */
// two flip-flop synchroniser for asynchronous pin inputs
`default_nettype none
module pmpl_sync #(
    parameter int          WIDTH = 1,
    parameter logic [31:0] INIT  = 32'h0000_0000
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } pmpl_sync_t;

    pmpl_sync_t s;
    pmpl_sync_t next_s;

    always_comb begin
        next_s        = s;
        next_s.meta   = async_i;
        next_s.stable = s.meta;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '{meta: INIT[WIDTH-1:0], stable: INIT[WIDTH-1:0]};
        end else begin
            s <= next_s;
        end
    end

    assign sync_o = s.stable;
endmodule // pmpl_sync
`default_nettype wire

/* src/pmpl_top.sv */
// power management pin logic: wishbone registers, pin muxing, wake gating, resets
`default_nettype none
// Notes on behaviour
// (RQ1) battery low blocks any wake from S3, S4 or S5
// (RQ2) an enable lets battery low assertion raise the system management interrupt
// (RQ3) if enabled, bus activity assertion sets the bus master status flag
// (RQ4) if enabled, bus activity is forwarded on the pm sync line
// (RQ5) native mode drives both core voltage id outputs high only
// (RQ6) native mode never drives the external power gate output low
// (RQ7) deep sleep from S4/S5 may be limited to battery operation via ac present
// (RQ8) active-low open-drain dram reset holds memory in reset while low
// (RQ9) platform reset asserted whenever core power good is negated
// (RQ10) software hard reset holds platform reset active at least 1 ms
// (RQ11) multiplexed pins carry their function only in native mode, else gpio
module pmpl_top
    import pmpl_pkg::*;
#(
    parameter int unsigned HARD_CYCLES = HARD_RESET_CYCLES
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        battery_low_n_i,
    input  wire logic        bus_activity_n_i,
    input  wire logic        ac_power_present_i,
    input  wire logic        core_power_good_i,
    input  wire logic        wake_request_i,
    output logic             core_voltage_id_bit0_o,
    output logic             core_voltage_id_bit1_o,
    output logic             external_gate_n_o,
    output logic             platform_reset_n_o,
    output logic             dram_reset_n_o,
    output logic             dram_reset_oe_o,
    output logic             pm_sync_line_o,
    output logic             system_mgmt_interrupt_n_o,
    output logic             irq_o,
    output logic             wake_o,
    output logic             deep_sleep_state_o
);
    pmpl_state_t     s;
    pmpl_state_t     next_s;
    logic [IN_W-1:0] pin_raw;
    logic [IN_W-1:0] pin_q;
    logic            bat_low;
    logic            bus_active;
    logic            ac_present;
    logic            power_good;
    logic            wake_req;
    logic            bat_low_rise;
    logic            busy_rise;
    logic            wake_rise;
    logic            pg_fall;
    logic            wr;
    logic            rd;
    logic            hard_start;
    logic            hard_busy;
    logic [EV_W-1:0] int_clr;
    logic            bm_clr;
    logic [EV_W-1:0] events;
    logic            sleeping;
    logic            wake_refused;

    // idle levels: battery fine, bus idle, power good low until the rails settle
    assign pin_raw = {wake_request_i, core_power_good_i, ac_power_present_i,
                      ~bus_activity_n_i, ~battery_low_n_i};

    pmpl_sync #(
        .WIDTH (IN_W),
        .INIT  (32'h0000_0000)
    ) u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i (pin_raw),
        .sync_o  (pin_q)
    );

    assign bat_low    = pin_q[IN_LOWBAT];
    assign bus_active = pin_q[IN_BUSY];
    assign ac_present = pin_q[IN_AC];
    assign power_good = pin_q[IN_PG];
    assign wake_req   = pin_q[IN_WAKE];

    assign bat_low_rise = bat_low & ~s.bat_low_q;
    assign busy_rise    = bus_active & ~s.busy_q;
    assign wake_rise    = wake_req & ~s.wake_q;
    assign pg_fall      = ~power_good & s.pg_q;

    // a write or read takes effect in the cycle the ack is raised
    assign wr = wb_cyc_i & wb_stb_i & ~s.ack & wb_we_i & wb_sel_i[0];
    assign rd = wb_cyc_i & wb_stb_i & ~s.ack & ~wb_we_i;

    assign hard_start = wr & (wb_adr_i == OFS_RESET_CTRL) & wb_dat_i[RST_CTRL_HARD];
    assign int_clr    = (wr & (wb_adr_i == OFS_INT_CLEAR)) ? wb_dat_i[EV_W-1:0] : EV_RST;
    assign bm_clr     = wr & (wb_adr_i == OFS_PM_STATUS) & wb_dat_i[PMS_BM_FLAG];

    assign sleeping     = (s.sleep != PMPL_S0);
    assign wake_refused = wake_rise & sleeping & bat_low; // [RQ1]

    assign events = {pg_fall,
                     wake_rise & sleeping & ~bat_low,
                     wake_refused,
                     busy_rise,
                     bat_low_rise};

    pmpl_pulse #(
        .CYCLES (HARD_CYCLES)
    ) u_hard (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .start_i (hard_start),
        .busy_o  (hard_busy)
    );

    always_comb begin
        next_s       = s;
        next_s.ack   = wb_cyc_i & wb_stb_i & ~s.ack;
        next_s.rdata = 32'h0000_0000;
        next_s.wake  = 1'b0;

        if (wr) begin
            case (wb_adr_i)
                OFS_CTRL:       next_s.ctrl     = wb_dat_i[CTRL_W-1:0];
                OFS_NATIVE:     next_s.native   = wb_dat_i[MUX_W-1:0];
                OFS_GPIO_OUT:   next_s.gpio_out = wb_dat_i[MUX_W-1:0];
                OFS_SLEEP:      next_s.sleep    = pmpl_sleep_t'(wb_dat_i[1:0]);
                OFS_INT_ENABLE: next_s.int_en   = wb_dat_i[EV_W-1:0];
                default:        next_s.ctrl     = s.ctrl;
            endcase
        end

        // unmapped and write-only addresses read as zero
        if (rd) begin
            case (wb_adr_i)
                OFS_CTRL:       next_s.rdata = {26'h0, s.ctrl};
                OFS_NATIVE:     next_s.rdata = {28'h0, s.native};
                OFS_GPIO_OUT:   next_s.rdata = {28'h0, s.gpio_out};
                OFS_SLEEP:      next_s.rdata = {30'h0, s.sleep};
                OFS_RESET_CTRL: next_s.rdata = {30'h0, hard_busy, 1'b0};
                OFS_PM_STATUS:  next_s.rdata = {31'h0, s.bm_flag};
                OFS_INT_STATUS: next_s.rdata = {27'h0, s.int_sts};
                OFS_INT_ENABLE: next_s.rdata = {27'h0, s.int_en};
                OFS_PIN_STATUS: next_s.rdata = {25'h0, s.deep, s.plt_n, pin_q};
                default:        next_s.rdata = 32'h0000_0000;
            endcase
        end

        next_s.bat_low_q = bat_low;
        next_s.busy_q    = bus_active;
        next_s.wake_q    = wake_req;
        next_s.pg_q      = power_good;

        // sticky flags: a new event wins over a clear in the same cycle
        next_s.int_sts = (s.int_sts & ~int_clr) | events;
        next_s.bm_flag = (s.bm_flag & ~bm_clr)
                       | (busy_rise & s.ctrl[CTRL_BM_FLAG_EN]); // [RQ3]

        // a wake that is let through beats a same-cycle software sleep write
        if (wake_rise && sleeping && !bat_low) begin // [RQ1]
            next_s.sleep = PMPL_S0;
            next_s.wake  = 1'b1;
        end

        next_s.vid0   = s.native[PIN_VID0] | s.gpio_out[PIN_VID0]; // [RQ5] [RQ11]
        next_s.vid1   = s.native[PIN_VID1] | s.gpio_out[PIN_VID1]; // [RQ5] [RQ11]
        next_s.gate_n = s.native[PIN_GATE] | s.gpio_out[PIN_GATE]; // [RQ6] [RQ11]
        // power good comes through the synchroniser, so reset lags its fall by 3 clocks
        next_s.plt_n  = s.native[PIN_PLT] ? (power_good & ~hard_busy)
                                          : s.gpio_out[PIN_PLT]; // [RQ9] [RQ10] [RQ11]

        next_s.dram_n  = 1'b0;
        next_s.dram_oe = ~s.ctrl[CTRL_DRAM_REL]; // [RQ8]

        next_s.sync  = s.ctrl[CTRL_BM_SYNC_EN] & bus_active; // [RQ4]
        next_s.smi_n = ~(s.ctrl[CTRL_SMI_EN] & next_s.int_sts[EV_LOWBAT]); // [RQ2]
        next_s.irq   = |(next_s.int_sts & s.int_en);
        next_s.deep  = s.ctrl[CTRL_DEEP_EN]
                     & ((s.sleep == PMPL_S4) | (s.sleep == PMPL_S5))
                     & ~(s.ctrl[CTRL_BATT_ONLY] & ac_present); // [RQ7]
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= STATE_RST;
        end else begin
            s <= next_s;
        end
    end

    assign wb_dat_o                  = s.rdata;
    assign wb_ack_o                  = s.ack;
    assign core_voltage_id_bit0_o    = s.vid0;
    assign core_voltage_id_bit1_o    = s.vid1;
    assign external_gate_n_o         = s.gate_n;
    assign platform_reset_n_o        = s.plt_n;
    assign dram_reset_n_o            = s.dram_n;
    assign dram_reset_oe_o           = s.dram_oe;
    assign pm_sync_line_o            = s.sync;
    assign system_mgmt_interrupt_n_o = s.smi_n;
    assign irq_o                     = s.irq;
    assign wake_o                    = s.wake;
    assign deep_sleep_state_o        = s.deep;

    // checks
    property p_wake_block;
        @(posedge clk_i) disable iff (rst_i)
        wake_refused |=> (!wake_o && s.int_sts[EV_BLOCKED] && s.sleep != PMPL_S0);
    endproperty
    a_wake_block: assert property (p_wake_block) else $error("wake let through on low battery"); // [RQ1]

    property p_smi;
        @(posedge clk_i) disable iff (rst_i)
        (bat_low_rise && s.ctrl[CTRL_SMI_EN]) |=> !system_mgmt_interrupt_n_o;
    endproperty
    a_smi: assert property (p_smi) else $error("battery low did not raise smi"); // [RQ2]

    property p_bm_flag;
        @(posedge clk_i) disable iff (rst_i)
        (busy_rise && s.ctrl[CTRL_BM_FLAG_EN]) |=> s.bm_flag;
    endproperty
    a_bm_flag: assert property (p_bm_flag) else $error("bus master flag not set"); // [RQ3]

    property p_sync;
        @(posedge clk_i) disable iff (rst_i)
        ##1 (pm_sync_line_o == $past(s.ctrl[CTRL_BM_SYNC_EN] && bus_active));
    endproperty
    a_sync: assert property (p_sync) else $error("sync line does not follow bus activity"); // [RQ4]

    property p_vid;
        @(posedge clk_i) disable iff (rst_i)
        (s.native[PIN_VID0] && s.native[PIN_VID1])
            |=> (core_voltage_id_bit0_o && core_voltage_id_bit1_o);
    endproperty
    a_vid: assert property (p_vid) else $error("voltage id low in native mode"); // [RQ5]

    property p_gate;
        @(posedge clk_i) disable iff (rst_i)
        s.native[PIN_GATE] |=> external_gate_n_o;
    endproperty
    a_gate: assert property (p_gate) else $error("power gate driven low in native mode"); // [RQ6]

    property p_deep;
        @(posedge clk_i) disable iff (rst_i)
        (s.ctrl[CTRL_BATT_ONLY] && ac_present) |=> !deep_sleep_state_o;
    endproperty
    a_deep: assert property (p_deep) else $error("deep sleep entered on ac power"); // [RQ7]

    property p_dram;
        @(posedge clk_i) disable iff (rst_i)
        !s.ctrl[CTRL_DRAM_REL] |=> (dram_reset_oe_o && !dram_reset_n_o);
    endproperty
    a_dram: assert property (p_dram) else $error("dram reset released while held"); // [RQ8]

    property p_power_good;
        @(posedge clk_i) disable iff (rst_i)
        (!power_good && s.native[PIN_PLT]) |=> !platform_reset_n_o;
    endproperty
    a_power_good: assert property (p_power_good) else $error("no platform reset on power fail"); // [RQ9]

    property p_hard;
        @(posedge clk_i) disable iff (rst_i)
        (hard_start && s.native[PIN_PLT]) ##1 s.native[PIN_PLT]
            |=> (!platform_reset_n_o && hard_busy) [*8];
    endproperty
    a_hard: assert property (p_hard) else $error("hard reset not held"); // [RQ10]

    property p_gpio_mux;
        @(posedge clk_i) disable iff (rst_i)
        !s.native[PIN_PLT] |=> (platform_reset_n_o == $past(s.gpio_out[PIN_PLT]));
    endproperty
    a_gpio_mux: assert property (p_gpio_mux) else $error("gpio pin not following output"); // [RQ11]

    c_wake: cover property (@(posedge clk_i) disable iff (rst_i) wake_o);
    c_refused: cover property (@(posedge clk_i) disable iff (rst_i) wake_refused);
    c_hard: cover property (@(posedge clk_i) disable iff (rst_i) hard_start ##2 hard_busy);
    c_smi: cover property (@(posedge clk_i) disable iff (rst_i) !system_mgmt_interrupt_n_o);
endmodule // pmpl_top
`default_nettype wire
